// ===== hdl/adc_ctrl_pkg.sv
// constants, register map and state types of the converter control block
// assumes a 125 MHz system clock and an APB master with 32-bit data
package adc_ctrl_pkg;

   localparam int          CLK_MHZ     = 125;
   // stabilisation time after leaving halt, in ns; the real figure is part specific
   localparam int          STAB_NS     = 2000;
   localparam int          STAB_INT    = (STAB_NS * CLK_MHZ + 999) / 1000;
   localparam int          STAB_W      = 9;
   localparam logic [8:0]  STAB_CYC    = 9'(STAB_INT);

   localparam int          RESULT_W    = 10;
   localparam int          HIGH_LSB    = 2;
   localparam int          FIFO_DEPTH  = 32;
   localparam int          NUM_CH      = 6;

   // printed register indices; byte address is four times the index
   localparam logic [7:0]  LOW_IDX     = 8'h6F;
   localparam logic [7:0]  HIGH_IDX    = 8'h70;
   localparam logic [7:0]  CSR_IDX     = 8'h71;
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] LOW_ADDR    = {2'h0, LOW_IDX, 2'h0};
   localparam logic [11:0] HIGH_ADDR   = {2'h0, HIGH_IDX, 2'h0};
   localparam logic [11:0] CSR_ADDR    = {2'h0, CSR_IDX, 2'h0};

   localparam int          DONE_BIT    = 7;
   localparam int          SPEED_BIT   = 6;
   localparam int          ON_BIT      = 5;
   localparam int          SLOW_BIT    = 4;
   localparam int          CHAN_LSB    = 0;
   localparam int          CHAN_W      = 3;
   localparam logic [7:0]  CSR_RESET   = 8'h00;

   // converter clock selection by {slow, speed}
   localparam logic [1:0]  SEL_FULL    = 2'h1;
   localparam logic [1:0]  SEL_HALF    = 2'h0;
   localparam logic [1:0]  SEL_QUARTER = 2'h2;
   localparam logic [1:0]  SEL_HALF_B  = 2'h3;
   localparam logic [1:0]  DIV_LAST    = 2'h3;

   typedef struct packed {
      logic                 done;
      logic                 speed;
      logic                 on;
      logic                 slow;
      logic [CHAN_W-1:0]    chan;
      logic                 lock;
      logic [7:0]           high;
      logic [1:0]           low;
      logic [1:0]           div;
      logic                 tick;
      logic                 en;
      logic [STAB_W-1:0]    stab;
      logic [31:0]          prdata;
      logic                 slverr;
   } ctrl_state_type;

endpackage : adc_ctrl_pkg

// ===== hdl/result_stream_if.sv
// valid/ready word stream between the control logic and its result fifo
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface result_stream_if #(parameter int WIDTH = 10) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : result_stream_if
`default_nettype wire

// ===== hdl/result_fifo.sv
// synchronous fifo for converter results, parameterised in width and depth
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       flush_i,
   result_stream_if.sink   in_s,
   result_stream_if.source out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } fifo_state_type;

   fifo_state_type s;
   fifo_state_type next_s;
   logic           push;
   logic           pop;

   assign in_s.ready  = (s.cnt != FULL_CNT);
   assign out_s.valid = (s.cnt != '0);
   assign out_s.data  = s.mem[s.rd];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_s.data;
         next_s.wr        = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      // a flush drops queued words so a stopped converter leaves nothing behind
      if (flush_i) begin
         next_s.wr  = '0;
         next_s.rd  = '0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_full_refuses: assert property (s.cnt == FULL_CNT |-> !in_s.ready)
      else $error("fifo accepts while full");
   a_count_tracks: assert property ((push && !pop && !flush_i) |=> s.cnt == $past(s.cnt) + 1'b1)
      else $error("fifo count did not follow a push");

endmodule : result_fifo
`default_nettype wire

// ===== hdl/adc_control_result_regs.sv
// control/status and result registers of a 10-bit six-channel converter, APB slave
// assumes a synchronous analog core stepped by core_tick_o that holds its result
// while core_valid_i is high until core_ready_o accepts it
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_control_result_regs
   import adc_ctrl_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [ADDR_W-1:0]   paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   input  wire logic                halt_i,
   input  wire logic                core_valid_i,
   input  wire logic [RESULT_W-1:0] core_result_i,
   output logic                     core_ready_o,
   output logic                     core_enable_o,
   output logic                     core_tick_o,
   output logic      [CHAN_W-1:0]   core_channel_o
);

   ctrl_state_type s;
   ctrl_state_type next_s;
   logic           setup;
   logic           access;
   logic           wr_csr;
   logic           rd_hi;
   logic           rd_lo;
   logic           pop_fire;
   logic           tick_sel;

   result_stream_if #(.WIDTH(RESULT_W)) fill_s ();
   result_stream_if #(.WIDTH(RESULT_W)) drain_s ();

   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .flush_i   (!s.on),
      .in_s      (fill_s.sink),
      .out_s     (drain_s.source)
   );

   // results from the core; anything arriving while off or still settling is dropped
   assign fill_s.valid   = core_valid_i && s.en && (s.stab == '0);
   assign fill_s.data    = core_result_i;
   assign core_ready_o   = fill_s.ready;
   // a locked pair stalls the drain; the fifo then fills and holds the core back
   // no pop while a result read is on the bus, so a read never splits a pair or loses done
   assign drain_s.ready  = !s.lock && !(psel_i && !pwrite_i &&
                                        (paddr_i == LOW_ADDR || paddr_i == HIGH_ADDR));
   assign pop_fire       = drain_s.valid && drain_s.ready;

   assign setup     = psel_i && !penable_i;
   assign access    = psel_i && penable_i;
   assign wr_csr    = access && pwrite_i && (paddr_i == CSR_ADDR);
   assign rd_hi     = access && !pwrite_i && (paddr_i == HIGH_ADDR);
   assign rd_lo     = access && !pwrite_i && (paddr_i == LOW_ADDR);

   assign pready_o       = penable_i;
   assign prdata_o       = s.prdata;
   assign pslverr_o      = s.slverr && penable_i;
   assign core_enable_o  = s.en;
   assign core_tick_o    = s.tick;
   assign core_channel_o = s.chan;

   always_comb begin
      next_s   = s;
      tick_sel = 1'b0;

      // read data is captured in the setup cycle so prdata comes from a flop
      if (setup) begin
         next_s.slverr = 1'b0;
         unique case (paddr_i)
            LOW_ADDR:  next_s.prdata = {30'h0, s.low};
            HIGH_ADDR: next_s.prdata = {24'h0, s.high};
            CSR_ADDR:  next_s.prdata = {24'h0, s.done, s.speed, s.on, s.slow,
                                        1'b0, s.chan};
            default: begin
               next_s.prdata = 32'h0;
               next_s.slverr = 1'b1;
            end
         endcase
      end

      if (wr_csr) begin
         next_s.speed = pwdata_i[SPEED_BIT];
         next_s.on    = pwdata_i[ON_BIT];
         next_s.slow  = pwdata_i[SLOW_BIT];
         next_s.chan  = pwdata_i[CHAN_LSB +: CHAN_W];
         next_s.done  = 1'b0;
      end
      if (rd_hi) begin
         next_s.done = 1'b0;
         next_s.lock = 1'b0;
      end
      if (rd_lo) begin
         next_s.lock = 1'b1;
      end
      // a new result wins over a clear in the same cycle
      if (pop_fire) begin
         next_s.high = drain_s.data[RESULT_W-1:HIGH_LSB];
         next_s.low  = drain_s.data[HIGH_LSB-1:0];
         next_s.done = 1'b1;
      end

      // no wait input exists: the converter keeps running through processor wait
      if (halt_i) begin
         next_s.stab = STAB_CYC;
      end else if (s.stab != '0) begin
         next_s.stab = s.stab - 1'b1;
      end
      next_s.en = next_s.on && !halt_i;

      unique case ({s.slow, s.speed})
         SEL_FULL:    tick_sel = 1'b1;
         SEL_HALF:    tick_sel = s.div[0];
         SEL_HALF_B:  tick_sel = s.div[0];
         SEL_QUARTER: tick_sel = (s.div == DIV_LAST);
      endcase
      if (s.en && next_s.en) begin
         next_s.div  = s.div + 1'b1;
         next_s.tick = tick_sel;
      end else begin
         next_s.div  = '0;
         next_s.tick = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence steady_quarter;
      s.tick && s.slow && !s.speed && !wr_csr;
   endsequence

   sequence low_then_high;
      rd_lo ##1 (!rd_hi)[*2];
   endsequence

   a_result_done: assert property (pop_fire |=> s.done &&
         s.high == $past(drain_s.data[RESULT_W-1:HIGH_LSB]))
      else $error("result not latched with done flag");
   a_ready_latch: assert property ((fill_s.valid && fill_s.ready) |->
         ##[1:40] (s.done || s.lock || !s.on))
      else $error("accepted result never reached the registers");
   a_high_read_clears: assert property ((rd_hi && !pop_fire) |=> !s.done)
      else $error("high read left done set");
   a_csr_write_clears: assert property ((wr_csr && !pop_fire) |=> !s.done)
      else $error("status write left done set");
   a_lock_freezes: assert property (low_then_high |-> $stable(s.high))
      else $error("high result changed while locked");
   a_channel_routed: assert property (wr_csr |=> core_channel_o == $past(pwdata_i[2:0]))
      else $error("channel select not routed");
   a_off_disables: assert property ((wr_csr && !pwdata_i[ON_BIT]) |=> !core_enable_o && !core_tick_o)
      else $error("converter still enabled after off");
   a_halt_disables: assert property (halt_i |=> !core_enable_o && s.stab == STAB_CYC)
      else $error("converter not disabled in halt");
   a_settle_blocks: assert property ((s.stab != '0 && !drain_s.valid) |=> !drain_s.valid)
      else $error("result accepted before stabilisation");
   a_quarter_rate: assert property (steady_quarter |=> !s.tick)
      else $error("quarter rate tick too close");
   a_low_upper_zero: assert property ((setup && paddr_i == LOW_ADDR) |=> s.prdata[31:2] == 30'h0)
      else $error("low result upper bits not zero");
   a_low_read_locks: assert property (rd_lo |=> s.lock)
      else $error("low read did not lock the high result");
   a_tick_needs_enable: assert property (core_tick_o |-> core_enable_o)
      else $error("converter stepped while disabled");

endmodule : adc_control_result_regs
`default_nettype wire

// ===== tb/analog_core_model.sv
// behavioural model of the analog converter core behind the control block
// assumes the block steps it with a one-cycle tick and accepts by valid and ready
`timescale 1ns/100ps
`default_nettype none
module analog_core_model #(
   parameter int CONV_TICKS = 16
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       enable_i,
   input  wire logic       tick_i,
   input  wire logic       ready_i,
   input  wire logic [9:0] level_i,
   output logic            valid_o,
   output logic      [9:0] result_o = 10'h155
);
   int count;
   // a released result line toggles so a stale value is never mistaken for data
   always @(posedge clk_i) begin
      if (!reset_n_i || !enable_i) begin
         count    <= 0;
         valid_o  <= 1'b0;
         result_o <= ~result_o;
      end else if (valid_o && ready_i) begin
         valid_o  <= 1'b0;
         result_o <= ~result_o;
      end else if (!valid_o && tick_i) begin
         if (count == CONV_TICKS - 1) begin
            count    <= 0;
            valid_o  <= 1'b1;
            result_o <= level_i;
         end else begin
            count <= count + 1;
         end
      end
   end
endmodule : analog_core_model
`default_nettype wire

// ===== tb/test_adc_control_result_regs.sv
// self-checking bench for the converter control block, apb master and core model
// assumes adc_ctrl_pkg and the design files in hdl/
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_result_regs
   import adc_ctrl_pkg::*;
;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, halt = 1'b0, pready, pslverr, err;
   logic        cvalid, cready, cen, ctick;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, seed = 32'h4723;
   logic [9:0]  cres, lv, level = '0;
   logic [2:0]  cchan, ch;
   logic [1:0]  sel;
   int          mismatches = 0, n_tests = 0, g;

   always #4 clk_i = ~clk_i;

   adc_control_result_regs adc_control_result_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .halt_i(halt), .core_valid_i(cvalid), .core_result_i(cres), .core_ready_o(cready),
      .core_enable_o(cen), .core_tick_o(ctick), .core_channel_o(cchan));
   analog_core_model analog_core_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .enable_i(cen), .tick_i(ctick), .ready_i(cready), .level_i(level),
      .valid_o(cvalid), .result_o(cres));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] csr_val(input logic [1:0] s, input logic on,
                                           input logic [2:0] c);
      return {24'h0, 1'b0, s[0], on, s[1], 1'b0, c};
   endfunction : csr_val
   function automatic int period(input logic [1:0] s);
      return (s == SEL_FULL) ? 1 : (s == SEL_QUARTER) ? 4 : 2;
   endfunction : period

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // request held from setup until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, output logic [31:0] r);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= csr_val(sel, 1'b0, ch) | {26'h0, w & rd[ON_BIT], 5'h0};
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic set_csr(input logic on);
      rd[ON_BIT] = on;
      apb(1'b1, CSR_ADDR, rd);
   endtask : set_csr
   task automatic wait_done();
      rd = '0;
      for (int k = 0; k < 400 && rd[DONE_BIT] !== 1'b1; k++) apb(1'b0, CSR_ADDR, rd);
      chk("done set", 32'h1, 32'(rd[DONE_BIT]));
   endtask : wait_done
   task automatic tick_gap();
      do @(posedge clk_i); while (ctick !== 1'b1);
      g = 0;
      do begin
         @(posedge clk_i);
         g++;
      end while (ctick !== 1'b1);
   endtask : tick_gap
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      wrap_up();
   end

   initial begin
      sel = SEL_QUARTER;
      ch = 3'h0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      apb(1'b0, CSR_ADDR, rd);
      chk("csr reset", {24'h0, CSR_RESET}, rd);
      apb(1'b0, HIGH_ADDR, rd);
      chk("high reset", 32'h0, rd);
      apb(1'b0, 12'h0F0, rd);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         sel = 2'(i);
         ch = 3'(seed % NUM_CH);
         set_csr(1'b0);
         set_csr(1'b1);
         tick_gap();
         chk("tick gap", 32'(period(sel)), 32'(g));
         chk("channel", 32'(ch), 32'(cchan));
         chk("enable", 32'h1, 32'(cen));
      end
      sel = SEL_QUARTER;
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         lv = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : seed[9:0];
         set_csr(1'b0);
         level <= lv;
         set_csr(1'b1);
         wait_done();
         if (i < 4) begin
            apb(1'b0, LOW_ADDR, rd);
            chk("low", {30'h0, lv[1:0]}, rd);
         end
         apb(1'b0, HIGH_ADDR, rd);
         chk("high", {24'h0, lv[9:2]}, rd);
         apb(1'b0, CSR_ADDR, rd);
         chk("done clear", 32'h0, 32'(rd[DONE_BIT]));
         rd[ON_BIT] = 1'b1;
      end
      level <= ~lv;
      apb(1'b0, LOW_ADDR, rd);
      repeat (200) @(posedge clk_i);
      apb(1'b0, HIGH_ADDR, rd);
      chk("locked high", {24'h0, lv[9:2]}, rd);
      apb(1'b0, LOW_ADDR, rd);
      for (int k = 0; k < 4000 && cready !== 1'b0; k++) @(posedge clk_i);
      chk("fifo full", 32'h0, 32'(cready));
      set_csr(1'b0);
      apb(1'b0, CSR_ADDR, rd);
      chk("done cleared by write", 32'h0, 32'(rd[DONE_BIT]));
      chk("disabled", 32'h0, 32'(cen));
      chk("flushed", 32'h1, 32'(cready));
      apb(1'b0, HIGH_ADDR, rd);
      repeat (200) @(posedge clk_i);
      apb(1'b0, CSR_ADDR, rd);
      chk("no result after stop", 32'h0, 32'(rd[DONE_BIT]));
      set_csr(1'b1);
      halt <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("halt disables", 32'h0, 32'(cen));
      apb(1'b0, HIGH_ADDR, rd);
      halt <= 1'b0;
      for (int k = 0; k < 25; k++) begin
         repeat (6) @(posedge clk_i);
         apb(1'b0, CSR_ADDR, rd);
         chk("settling", 32'h0, 32'(rd[DONE_BIT]));
      end
      wait_done();
      wrap_up();
   end
endmodule : test_adc_control_result_regs
`default_nettype wire
